//--- rtl/clock_sync_serial_port.sv
// Purpose: device end, clock synchronous serial port
// Assumes: timer3_pulse is a one-cycle pulse on mclk
// Notes: pin inputs pass two flops; master clock is not resynchronised
`timescale 1ns/10ps
`default_nettype none
`include "ssp_regs.svh"
module clock_sync_serial_port (
	input wire logic mclk,
	input wire logic rst,
	ssp_link_if.dev link,
	input wire logic clock_pin_enable,
	input wire logic data_input_enable,
	input wire logic data_output_enable,
	input wire logic start_condition_enable,
	input wire logic output_edge_select,
	input wire logic input_edge_select,
	input wire logic bit_order_select,
	input wire logic [1:0] clock_source_select,
	input wire logic clock_divide_by_eight,
	input wire logic input_pin_select,
	input wire logic out_pin_direction_bit,
	input wire logic port_out_value,
	input wire logic timer3_pulse,
	input wire logic shift_wr,
	input wire logic [7:0] shift_wdata,
	input wire logic count_wr,
	input wire logic [2:0] count_wdata,
	output logic [7:0] shift_register,
	output logic [7:0] receive_buffer,
	output logic [2:0] bit_count_field,
	output logic transfer_busy_flag,
	output logic receive_complete_flag,
	output logic transfer_done_interrupt,
	output logic out_pin_level,
	output logic in_pin_level
);
	import ssp_pkg::*;
	dev_state_t st_reg;
	dev_state_t st_next;
	logic master;
	logic enabled;
	logic sck_lvl;
	logic rise;
	logic fall;
	logic out_edge;
	logic smp_edge;
	logic idle_lvl;
	logic dline;
	logic cur_bit;
	logic src_tick;
	logic tick;
	logic start_det;
	logic [3:0] len;
	// --------------------------------
	// clock source and edges
	// --------------------------------
	assign master = clock_pin_enable;
	assign enabled = data_input_enable | data_output_enable;
	assign sck_lvl = master ? st_reg.gen_sck : st_reg.sck_s2;
	assign rise = sck_lvl & ~st_reg.sck_q;
	assign fall = ~sck_lvl & st_reg.sck_q;
	assign out_edge = output_edge_select ? rise : fall;
	assign smp_edge = input_edge_select ? out_edge : (output_edge_select ? fall : rise);
	assign idle_lvl = ~output_edge_select;
	assign dline = input_pin_select ? st_reg.sdo_s2 : st_reg.sdi_s2;
	assign cur_bit = (bit_order_select == `ORDER_MSB) ? st_reg.sh[7] : st_reg.sh[0];
	assign len = (st_reg.field == 3'h0) ? `FULL_LEN : {1'b0, st_reg.field};
	// idle clock level at the data fall marks a start
	assign start_det = start_condition_enable & data_input_enable & ~data_output_enable
		& st_reg.din_q & ~dline & (sck_lvl == idle_lvl);
	always_comb begin
		case (clock_source_select)
			`SRC_FS2: src_tick = st_reg.pre[0];
			`SRC_FS4: src_tick = &st_reg.pre[1:0];
			`SRC_FS16: src_tick = &st_reg.pre;
			default: src_tick = timer3_pulse;
		endcase
	end
	assign tick = src_tick & (~clock_divide_by_eight | (&st_reg.div8));
	// --------------------------------
	// transfer state machine
	// --------------------------------
	always_comb begin
		logic run;
		logic go_slave;
		logic [4:0] edges;
		run = 1'b0;
		go_slave = 1'b0;
		edges = {len, 1'b0};
		st_next = st_reg;
		st_next.irq = 1'b0;
		st_next.pre = st_reg.pre + 4'h1;
		if (src_tick) begin
			st_next.div8 = st_reg.div8 + 3'h1;
		end
		st_next.sck_s1 = link.sck;
		st_next.sck_s2 = st_reg.sck_s1;
		st_next.sdo_s1 = link.sdo;
		st_next.sdo_s2 = st_reg.sdo_s1;
		st_next.sdi_s1 = link.sdi;
		st_next.sdi_s2 = st_reg.sdi_s1;
		st_next.sck_q = sck_lvl;
		st_next.din_q = dline;
		st_next.ce_q = {output_edge_select, input_edge_select};
		case (st_reg.state)
			S_IDLE: begin
				st_next.gen_sck = idle_lvl;
				if (shift_wr) begin
					st_next.sh = shift_wdata;
				end
				if (count_wr) begin
					st_next.field = count_wdata;
				end else if (enabled && st_reg.ce_q != {output_edge_select, input_edge_select}) begin
					st_next.field = st_reg.field + 3'h1;
				end
				if (start_det) begin
					st_next.field = `RST_FIELD;
					st_next.len = `FULL_LEN;
					st_next.bits = 4'h0;
					st_next.gcnt = 5'h0;
					st_next.busy = 1'b1;
					st_next.rxc = 1'b0;
					st_next.state = S_SHIFT;
				end else if (shift_wr && data_output_enable && start_condition_enable) begin
					st_next.len = len;
					st_next.bits = 4'h0;
					st_next.gcnt = 5'h0;
					st_next.busy = 1'b1;
					st_next.rxc = 1'b0;
					st_next.sdo = 1'b1;
					st_next.state = S_START_HI;
				end else if (shift_wr && master && enabled && !start_condition_enable) begin
					st_next.len = len;
					st_next.bits = 4'h0;
					st_next.gcnt = 5'h0;
					st_next.busy = 1'b1;
					st_next.rxc = 1'b0;
					st_next.state = S_SHIFT;
				end else if (!master && enabled && !start_condition_enable && out_edge) begin
					go_slave = 1'b1;
					st_next.len = len;
					st_next.bits = 4'h0;
					st_next.busy = 1'b1;
					st_next.rxc = 1'b0;
					st_next.state = S_SHIFT;
				end
			end
			S_START_HI: begin
				if (tick) begin
					st_next.sdo = 1'b0;
					st_next.state = S_START_LO;
				end
			end
			S_START_LO: begin
				if (tick) begin
					st_next.state = S_SHIFT;
				end
			end
			S_SHIFT: begin
				run = 1'b1;
			end
			S_TAIL: begin
				st_next.sdo = 1'b1;
				if (tick) begin
					st_next.state = S_IDLE;
				end
			end
			default: begin
				st_next.state = S_IDLE;
			end
		endcase
		if (run || go_slave) begin
			if (out_edge && st_reg.bits < st_next.len) begin
				st_next.sdo = cur_bit;
			end
			if (smp_edge && st_reg.bits < st_next.len) begin
				if (bit_order_select == `ORDER_MSB) begin
					st_next.sh = {st_reg.sh[6:0], dline};
				end else begin
					st_next.sh = {dline, st_reg.sh[7:1]};
				end
				st_next.bits = st_reg.bits + 4'h1;
			end
			// toggles are counted so the clock always parks at idle
			if (master && tick && st_reg.gcnt < edges) begin
				st_next.gen_sck = ~st_reg.gen_sck;
				st_next.gcnt = st_reg.gcnt + 5'h1;
			end
			if (run && st_reg.bits == st_reg.len
				&& (!master || (st_reg.gcnt == edges && st_reg.sck_q == st_reg.gen_sck))) begin
				st_next.rxb = st_reg.sh;
				st_next.busy = 1'b0;
				st_next.irq = 1'b1;
				st_next.rxc = data_input_enable;
				st_next.field = `RST_FIELD;
				st_next.state = start_condition_enable ? S_TAIL : S_IDLE;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '{state: S_IDLE, field: `RST_FIELD, gen_sck: 1'b1, sck_q: 1'b1, sdo: 1'b1,
				sck_s1: 1'b1, sck_s2: 1'b1, sdo_s1: 1'b1, sdo_s2: 1'b1, sdi_s1: 1'b1, sdi_s2: 1'b1,
				din_q: 1'b1, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end
	// --------------------------------
	// pins and user outputs
	// --------------------------------
	assign link.sck_dev_o = st_reg.gen_sck;
	assign link.sck_dev_oe_n = ~clock_pin_enable;
	assign link.sdo_dev_o = data_output_enable ? st_reg.sdo : port_out_value;
	assign link.sdo_dev_oe_n = ~out_pin_direction_bit;
	assign shift_register = st_reg.sh;
	assign receive_buffer = st_reg.rxb;
	assign bit_count_field = st_reg.field;
	assign transfer_busy_flag = st_reg.busy;
	assign receive_complete_flag = st_reg.rxc;
	assign transfer_done_interrupt = st_reg.irq;
	assign out_pin_level = st_reg.sdo_s2;
	assign in_pin_level = st_reg.sdi_s2;
endmodule
`default_nettype wire

//--- rtl/serial_partner.sv
// Purpose: far end, 8-bit synchronous partner, master or slave
// Assumes: idle high clock, data out on falling, sampled on rising
// Notes: msb first; slave frames must be armed by go
`timescale 1ns/10ps
`default_nettype none
`include "ssp_regs.svh"
module serial_partner (
	input wire logic mclk,
	input wire logic rst,
	ssp_link_if.ptn link,
	input wire logic master_mode,
	input wire logic two_wire,
	input wire logic drive_data,
	input wire logic send_start,
	input wire logic go,
	input wire logic [7:0] tx_data,
	output logic [7:0] rx_data,
	output logic busy,
	output logic done
);
	import ssp_pkg::*;
	ptn_state_t st_reg;
	ptn_state_t st_next;
	logic sck_lvl;
	logic rise;
	logic fall;
	logic half;
	assign sck_lvl = master_mode ? st_reg.sck_o : st_reg.sck_s2;
	assign rise = sck_lvl & ~st_reg.sck_q;
	assign fall = ~sck_lvl & st_reg.sck_q;
	assign half = st_reg.hcnt == 8'(`PTN_HALF_CYC - 1);
	always_comb begin
		st_next = st_reg;
		st_next.done = 1'b0;
		st_next.sck_s1 = link.sck;
		st_next.sck_s2 = st_reg.sck_s1;
		st_next.din_s1 = link.sdo;
		st_next.din_s2 = st_reg.din_s1;
		st_next.sck_q = sck_lvl;
		st_next.hcnt = half ? 8'h0 : st_reg.hcnt + 8'h1;
		case (st_reg.state)
			P_IDLE: begin
				st_next.hcnt = 8'h0;
				if (go) begin
					st_next.sh = tx_data;
					st_next.bits = 4'h0;
					st_next.tog = 5'h0;
					st_next.busy = 1'b1;
					st_next.state = (master_mode && send_start) ? P_START_HI : P_RUN;
				end
			end
			P_START_HI: begin
				st_next.dout = 1'b1;
				if (half) begin
					st_next.state = P_START_LO;
				end
			end
			P_START_LO: begin
				st_next.dout = 1'b0;
				if (half) begin
					st_next.state = P_RUN;
				end
			end
			P_RUN: begin
				if (fall && st_reg.bits < `PTN_BITS) begin
					st_next.dout = st_reg.sh[7];
				end
				if (rise && st_reg.bits < `PTN_BITS) begin
					st_next.sh = {st_reg.sh[6:0], st_reg.din_s2};
					st_next.bits = st_reg.bits + 4'h1;
				end
				if (master_mode && half && st_reg.tog < `PTN_EDGES) begin
					st_next.sck_o = ~st_reg.sck_o;
					st_next.tog = st_reg.tog + 5'h1;
				end
				if (st_reg.bits == `PTN_BITS
					&& (!master_mode || (st_reg.tog == `PTN_EDGES && st_reg.sck_q == st_reg.sck_o))) begin
					st_next.rx = st_reg.sh;
					st_next.busy = 1'b0;
					st_next.done = 1'b1;
					st_next.state = P_IDLE;
				end
			end
			default: begin
				st_next.state = P_IDLE;
			end
		endcase
	end
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_reg <= '{state: P_IDLE, sck_o: 1'b1, dout: 1'b1, sck_s1: 1'b1, sck_s2: 1'b1,
				sck_q: 1'b1, din_s1: 1'b1, din_s2: 1'b1, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end
	assign link.sck_ptn_o = st_reg.sck_o;
	assign link.sck_ptn_oe_n = ~master_mode;
	assign link.sdo_ptn_o = st_reg.dout;
	assign link.sdo_ptn_oe_n = ~(two_wire & drive_data);
	assign link.sdi_ptn_o = two_wire ? 1'b1 : st_reg.dout;
	assign rx_data = st_reg.rx;
	assign busy = st_reg.busy;
	assign done = st_reg.done;
endmodule
`default_nettype wire

//--- rtl/ssp_link_if.sv
// Purpose: clock, data-out and data-in lines between port and partner
// Assumes: open lines pull high
// Notes: a driven low wins over a driven high
`timescale 1ns/10ps
`default_nettype none
interface ssp_link_if;
	logic sck_dev_o;
	logic sck_dev_oe_n;
	logic sck_ptn_o;
	logic sck_ptn_oe_n;
	logic sdo_dev_o;
	logic sdo_dev_oe_n;
	logic sdo_ptn_o;
	logic sdo_ptn_oe_n;
	logic sdi_ptn_o;
	logic sck;
	logic sdo;
	logic sdi;
	assign sck = (sck_dev_oe_n | sck_dev_o) & (sck_ptn_oe_n | sck_ptn_o);
	assign sdo = (sdo_dev_oe_n | sdo_dev_o) & (sdo_ptn_oe_n | sdo_ptn_o);
	assign sdi = sdi_ptn_o;
	modport dev (output sck_dev_o, sck_dev_oe_n, sdo_dev_o, sdo_dev_oe_n, input sck, sdo, sdi);
	modport ptn (output sck_ptn_o, sck_ptn_oe_n, sdo_ptn_o, sdo_ptn_oe_n, sdi_ptn_o, input sck, sdo);
endinterface
`default_nettype wire

//--- rtl/ssp_pkg.sv
// Purpose: types shared by both ends of the serial link
// Assumes: nothing
// Notes: each module keeps all its state in one struct
package ssp_pkg;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_START_HI = 3'h1,
		S_START_LO = 3'h2,
		S_SHIFT = 3'h3,
		S_TAIL = 3'h4
	} dev_fsm_t;
	typedef enum logic [1:0] {
		P_IDLE = 2'h0,
		P_START_HI = 2'h1,
		P_START_LO = 2'h2,
		P_RUN = 2'h3
	} ptn_fsm_t;
	typedef struct packed {
		dev_fsm_t state;
		logic [7:0] sh;
		logic [7:0] rxb;
		logic [2:0] field;
		logic [3:0] bits;
		logic [3:0] len;
		logic [4:0] gcnt;
		logic busy;
		logic rxc;
		logic irq;
		logic sdo;
		logic gen_sck;
		logic [3:0] pre;
		logic [2:0] div8;
		logic sck_s1;
		logic sck_s2;
		logic sck_q;
		logic sdo_s1;
		logic sdo_s2;
		logic sdi_s1;
		logic sdi_s2;
		logic din_q;
		logic [1:0] ce_q;
	} dev_state_t;
	typedef struct packed {
		ptn_fsm_t state;
		logic [7:0] sh;
		logic [7:0] rx;
		logic [3:0] bits;
		logic [4:0] tog;
		logic [7:0] hcnt;
		logic sck_o;
		logic dout;
		logic busy;
		logic done;
		logic sck_s1;
		logic sck_s2;
		logic sck_q;
		logic din_s1;
		logic din_s2;
	} ptn_state_t;
endpackage

//--- rtl/ssp_regs.svh
// Purpose: constants for the clock synchronous serial port and its partner
// Assumes: mclk is the system clock at 100 MHz
// Notes: field code 000 means an 8-bit frame
//
// Contract
// - master receive: clock pin, enables, dummy write
// - enabled output pin keeps general input only
// - data enables set last, they enable traffic
// - master mode sets clock pin first
// - frame length 1..8 from 3-bit field
// - field changes after frame; rewrite unless 8
// - edge flag change while enabled bumps field
// - start condition clears counter, starts transfer
// - start is data fall with clock at idle
// - start mode drives out high half period
// - received start forces 8-bit frame
// - no start mode with duplex traffic
// - bit order flag picks msb or lsb first
// - switch direction one enable per write
// - short transmit uses upper or lower bits
// - completion copies shift register into buffer
// - receive flag set with completion when input
// - short receive lands lower or upper bits
// - edge flags pick output and sample edges
// - clock source select plus divide by eight
// - input pin select, two-wire uses direction bit
// - busy set at activation, cleared at completion
// - master makes clock, slave follows pin
// - 8-bit shift register plus receive buffer
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
`define RST_FIELD 3'h0
`define FULL_LEN 4'h8
`define SRC_FS2 2'h0
`define SRC_FS4 2'h1
`define SRC_FS16 2'h2
`define SRC_TMR3 2'h3
`define ORDER_MSB 1'b0
`define PTN_BITS 4'h8
`define PTN_EDGES 5'h10
`define MCLK_PERIOD_NS 10
`define PTN_HALF_NS 200
`define PTN_HALF_CYC (`PTN_HALF_NS / `MCLK_PERIOD_NS)
`endif

//--- test/clock_sync_serial_port_tb_top.sv
// Purpose: port against partner, both directions and both wirings
// Assumes: inputs change on falling mclk
// Notes: expected values queued, compared on done pulses
`timescale 1ns/10ps
`default_nettype none
module clock_sync_serial_port_tb_top;
	typedef struct packed {logic [7:0] v; logic [7:0] m;} exp_t;
	logic mclk = '0, rst = '1, clock_pin_enable = '0, data_input_enable = '0, data_output_enable = '0;
	logic start_condition_enable = '0, output_edge_select = '0, input_edge_select = '0, bit_order_select = '0;
	logic clock_divide_by_eight = '0, input_pin_select = '0, out_pin_direction_bit = '0, port_out_value = '0;
	logic timer3_pulse = '0, shift_wr = '0, count_wr = '0, master_mode = '0, two_wire = '0, drive_data = '0;
	logic send_start = '0, go = '0;
	logic [1:0] clock_source_select = '0;
	logic [2:0] count_wdata = '0, t3c = '0, bit_count_field;
	logic [7:0] shift_wdata = '0, tx_data = '0, prx = '0, shift_register, receive_buffer, rx_data;
	logic transfer_busy_flag, receive_complete_flag, transfer_done_interrupt, out_pin_level, in_pin_level, busy, done;
	exp_t qd[$], qp[$], e;
	int n_mismatch = 0, compares = 0, seed = 79;
	ssp_link_if link ();
	clock_sync_serial_port clock_sync_serial_port_i (.mclk, .rst, .link(link), .clock_pin_enable,
		.data_input_enable, .data_output_enable, .start_condition_enable, .output_edge_select,
		.input_edge_select, .bit_order_select, .clock_source_select, .clock_divide_by_eight, .input_pin_select,
		.out_pin_direction_bit, .port_out_value, .timer3_pulse, .shift_wr, .shift_wdata, .count_wr, .count_wdata,
		.shift_register, .receive_buffer, .bit_count_field, .transfer_busy_flag, .receive_complete_flag,
		.transfer_done_interrupt, .out_pin_level, .in_pin_level);
	serial_partner serial_partner_i (.mclk, .rst, .link(link), .master_mode, .two_wire, .drive_data,
		.send_start, .go, .tx_data, .rx_data, .busy, .done);
	ssp_checker ssp_checker_i (.mclk, .rst, .sck_dev_o(link.sck_dev_o), .data_input_enable, .receive_buffer,
		.bit_count_field, .transfer_busy_flag, .receive_complete_flag, .transfer_done_interrupt);
	always #5 mclk = ~mclk;
	// steady timer source so the partner can follow every edge
	always @(negedge mclk) begin
		t3c <= t3c + 3'h1;
		timer3_pulse <= t3c == 3'h0;
	end
	// ----------
	// checking
	// ----------
	task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got, input logic [7:0] m);
		compares++;
		if ((got & m) !== (exp & m)) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	always @(negedge mclk) begin
		if (transfer_done_interrupt === 1'b1) begin
			e = qd.pop_front();
			check8("receive_buffer", e.v, receive_buffer, e.m);
			check8("shift_register", e.v, shift_register, e.m);
			check8("receive_complete_flag", 8'(data_input_enable), 8'(receive_complete_flag), 8'h1);
		end
		if (done === 1'b1) begin
			e = qp.pop_front();
			check8("partner rx_data", e.v, rx_data, e.m);
		end
	end
	task automatic finish_test();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ten times the expected run
	initial begin
		repeat (40000) @(posedge mclk);
		n_mismatch++;
		finish_test();
	end
	// ----------
	// stimulus
	// ----------
	task automatic settle();
		int t;
		t = 0;
		repeat (4) @(negedge mclk);
		while ((transfer_busy_flag | (busy & master_mode)) !== 1'b0 && t < 3000) begin
			@(negedge mclk);
			t++;
		end
		if (t >= 3000)
			n_mismatch++;
		// start-mode tail outlasts busy by one tick; writes during it are dropped
		repeat (20) @(negedge mclk);
	endtask
	// device master, partner slave armed on the first piece of its byte
	task automatic frame(input logic [1:0] src, input logic lsb, input int n, input int k0);
		logic [7:0] d, v, mk;
		d = 8'($random(seed));
		v = '0;
		mk = '0;
		clock_source_select = src;
		clock_divide_by_eight = ~src[1];
		bit_order_select = lsb;
		count_wdata = n[2:0];
		count_wr = 1'b1;
		@(negedge mclk);
		count_wr = 1'b0;
		if (k0 == 0) begin
			tx_data = 8'($random(seed));
			go = 1'b1;
			@(negedge mclk);
			go = 1'b0;
		end
		for (int i = 0; i < n; i++) begin
			v[lsb ? 8 - n + i : n - 1 - i] = tx_data[7 - k0 - i];
			mk[lsb ? 8 - n + i : n - 1 - i] = 1'b1;
			prx[7 - k0 - i] = lsb ? d[i] : d[7 - i];
		end
		qd.push_back('{v, mk});
		if (k0 + n == 8)
			qp.push_back('{prx, 8'hff});
		shift_wdata = d;
		shift_wr = 1'b1;
		@(negedge mclk);
		shift_wr = 1'b0;
		settle();
	endtask
	initial begin
		repeat (4) @(negedge mclk);
		rst = 1'b0;
		repeat (3) @(negedge mclk);
		data_output_enable = 1'b1;
		out_pin_direction_bit = 1'b1;
		repeat (4) @(negedge mclk);
		check8("sdo line", 8'h1, 8'(link.sdo), 8'h1);
		data_output_enable = 1'b0;
		repeat (4) @(negedge mclk);
		check8("out_pin_level", 8'h0, 8'(out_pin_level), 8'h1);
		check8("in_pin_level", 8'h1, 8'(in_pin_level), 8'h1);
		data_input_enable = 1'b1;
		@(negedge mclk);
		input_edge_select = 1'b1;
		repeat (3) @(negedge mclk);
		check8("bit_count_field", 8'h1, 8'(bit_count_field), 8'h7);
		data_input_enable = 1'b0;
		@(negedge mclk);
		input_edge_select = 1'b0;
		clock_pin_enable = 1'b1;
		@(negedge mclk);
		data_input_enable = 1'b1;
		@(negedge mclk);
		data_output_enable = 1'b1;
		for (int s = 0; s < 8; s++)
			frame(2'(s / 2), s[0], 8, 0);
		for (int b = 0; b < 2; b++) begin
			frame(2'h2, b[0], b ? 1 : 4, 0);
			frame(2'h2, b[0], b ? 7 : 4, b ? 1 : 4);
		end
		// start mode as master is transmit only, so input is dropped first
		data_output_enable = 1'b0;
		@(negedge mclk);
		data_input_enable = 1'b0;
		start_condition_enable = 1'b1;
		@(negedge mclk);
		data_output_enable = 1'b1;
		frame(2'h2, 1'b0, 8, 0);
		check8("sdo tail level", 8'h1, 8'(link.sdo), 8'h1);
		data_output_enable = 1'b0;
		@(negedge mclk);
		data_input_enable = 1'b0;
		clock_pin_enable = 1'b0;
		out_pin_direction_bit = 1'b0;
		bit_order_select = 1'b0;
		master_mode = 1'b1;
		for (int m = 0; m < 2; m++) begin
			start_condition_enable = m == 0;
			send_start = m == 0;
			input_pin_select = m[0];
			two_wire = m[0];
			drive_data = m[0];
			count_wdata = m ? 3'h0 : 3'h3;
			count_wr = 1'b1;
			@(negedge mclk);
			count_wr = 1'b0;
			tx_data = 8'($random(seed));
			qd.push_back('{tx_data, 8'hff});
			qp.push_back('{m ? tx_data : 8'hff, 8'hff});
			data_input_enable = 1'b1;
			@(negedge mclk);
			go = 1'b1;
			@(negedge mclk);
			go = 1'b0;
			settle();
			data_input_enable = 1'b0;
		end
		finish_test();
	end
endmodule
`default_nettype wire

//--- test/ssp_checker.sv
// Purpose: timing checks on the serial port flags and clock pin
// Assumes: one clock domain, mclk
// Notes: watches device outputs plus data_input_enable
`timescale 1ns/10ps
`default_nettype none
module ssp_checker (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sck_dev_o,
	input wire logic data_input_enable,
	input wire logic [7:0] receive_buffer,
	input wire logic [2:0] bit_count_field,
	input wire logic transfer_busy_flag,
	input wire logic receive_complete_flag,
	input wire logic transfer_done_interrupt
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (rst);
	// ----------
	// completion
	// ----------
	property p_done_ends_busy;
		transfer_done_interrupt |-> $fell(transfer_busy_flag);
	endproperty
	a_done_ends_busy: assert property (p_done_ends_busy) else $error("done without busy falling");
	property p_done_pulse;
		transfer_done_interrupt |=> !transfer_done_interrupt;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
	// bound covers the slowest source used here
	property p_busy_bound;
		$rose(transfer_busy_flag) |-> ##[1:1000] transfer_done_interrupt;
	endproperty
	a_busy_bound: assert property (p_busy_bound) else $error("frame never completed");
	property p_buf_on_done;
		$changed(receive_buffer) |-> transfer_done_interrupt;
	endproperty
	a_buf_on_done: assert property (p_buf_on_done) else $error("buffer changed outside completion");
	property p_rxc_set;
		$rose(receive_complete_flag) |-> transfer_done_interrupt && data_input_enable;
	endproperty
	a_rxc_set: assert property (p_rxc_set) else $error("receive flag set without completion");
	property p_rxc_clr;
		$fell(receive_complete_flag) |-> transfer_busy_flag;
	endproperty
	a_rxc_clr: assert property (p_rxc_clr) else $error("receive flag cleared while idle");
	property p_field_back;
		transfer_done_interrupt |-> ##[0:1] bit_count_field == 3'h0;
	endproperty
	a_field_back: assert property (p_field_back) else $error("count field not back to zero");
	property p_sck_busy;
		$changed(sck_dev_o) |-> transfer_busy_flag || $past(transfer_busy_flag);
	endproperty
	a_sck_busy: assert property (p_sck_busy) else $error("clock pin moved while idle");
endmodule
`default_nettype wire
